// *** verilog/wave_bridge_regs.vh ***
`ifndef WAVE_BRIDGE_REGS_VH
`define WAVE_BRIDGE_REGS_VH

// register indices on the plain port
`define ADDR_CONTROL_MAIN      4'h0
`define ADDR_POLARITY_INPUT    4'h1
`define ADDR_CLOCK_SELECT      4'h2
`define ADDR_INPUT_SELECT      4'h3
`define ADDR_STEERING          4'h4
`define ADDR_SHUTDOWN_CONTROL  4'h5
`define ADDR_SHUTDOWN_SOURCES  4'h6
`define ADDR_RISE_DEADBAND     4'h7
`define ADDR_FALL_DEADBAND     4'h8
`define ADDR_MODULE_DISABLE    4'h9
`define ADDR_IRQ_STATUS        4'hA
`define ADDR_IRQ_MASK          4'hB
`define ADDR_STATE             4'hC

// field positions
`define CTRL_EN_BIT            7
`define CTRL_LOAD_BIT          6
`define MODE_LSB_BIT           0
`define MODE_HI_MSB            2
`define MODE_HI_LSB            1
`define POL_IN_BIT             5
`define CLK_SEL_BIT            0
`define MODE_MSB               2
`define ISM_MSB                2
`define ISM_LSB                0
`define POL_A_BIT              0
`define POL_B_BIT              1
`define POL_C_BIT              2
`define POL_D_BIT              3

// mode codes
`define MODE_FWD_FULL          3'h2
`define MODE_REV_FULL          3'h3
`define MODE_FULL_HI           2'h1

// interrupt status bits
`define IRQ_DIR_CHANGE         0
`define IRQ_DEADBAND_DONE      1

// reset values and the count step
`define RESET_BYTE             8'h00
`define RESET_COUNT            6'h00
`define ONE_COUNT              6'h01

`endif

// *** verilog/deadband_counter.v ***
`include "wave_bridge_regs.vh"

module deadband_counter (
	// clock and reset
	input  wire       clk,
	input  wire       rst,
	// control
	input  wire       tick,
	input  wire       start,
	input  wire [5:0] length,
	// status
	output reg        busy_q,
	output reg        done_q
);

	reg [5:0] count_q;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= `RESET_COUNT;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				// zero length still costs nothing beyond the restart
				count_q <= length;
				busy_q  <= (length != `RESET_COUNT);
				done_q  <= (length == `RESET_COUNT);
			end else if (busy_q && tick) begin
				if (count_q == `ONE_COUNT) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
				count_q <= count_q - `ONE_COUNT;
			end
		end
	end

endmodule

// *** verilog/wave_bridge.v ***
// What this block does
// R1: forward full-bridge mode drives A active, B and C inactive, and D with the modulating input.
// R2: reverse full-bridge mode drives C active, A and D inactive, and B with the modulating input.
// R3: every change of direction in full-bridge mode passes through a dead-band before the new output modulates.
// R4: steering and override settings are ignored in both full-bridge modes.
// R5: software may flip direction through the lowest mode bit while enabled, without disabling first.
// R6: while the module-disable bit is set the generator is held in reset and its clock enable is removed.
// R7: turning to reverse counts the rising dead-band setting, turning to forward the falling one, in generator clocks.
//
// Design decisions made here: the strobed register port and the address map.
`include "wave_bridge_regs.vh"

module wave_bridge (
	// clock and reset
	input  wire       SYS_CLK,
	input  wire       RESET,
	// register port
	input  wire [3:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	// modulation sources and peripheral clock choice
	input  wire [7:0] MOD_SOURCES,
	input  wire       ALT_CLK_EN,
	// bridge outputs
	output reg        BRIDGE_OUT_A,
	output reg        BRIDGE_OUT_B,
	output reg        BRIDGE_OUT_C,
	output reg        BRIDGE_OUT_D,
	// interrupt
	output reg        IRQ
);

	////////////////////////////////////////////////////////////////
	// registers

	reg [7:0] control_main_q;
	reg [7:0] polarity_input_q;
	reg [7:0] clock_select_q;
	reg [7:0] input_select_q;
	reg [7:0] steering_q;
	reg [7:0] shutdown_control_q;
	reg [7:0] shutdown_sources_q;
	reg [5:0] rise_deadband_q;
	reg [5:0] fall_deadband_q;
	reg       module_disable_q;
	reg [1:0] irq_status_q;
	reg [1:0] irq_mask_q;

	reg       dir_rev_q;
	reg       dead_q;
	reg       in_q;
	reg       was_full_q;

	wire       gen_rst;
	wire       tick;
	wire [2:0] mode;
	wire       full_mode;
	wire       enabled;
	wire       mod_raw;
	wire       dir_change;
	wire       db_busy;
	wire       db_done;
	wire [5:0] db_len;

	function is_full;
		input [2:0] m;
		begin
			is_full = (m[`MODE_HI_MSB:`MODE_HI_LSB] == `MODE_FULL_HI);
		end
	endfunction

	function [7:0] sel_word;
		input [3:0] a;
		begin
			case (a)
				`ADDR_CONTROL_MAIN:     sel_word = control_main_q;
				`ADDR_POLARITY_INPUT:   sel_word = polarity_input_q;
				`ADDR_CLOCK_SELECT:     sel_word = clock_select_q;
				`ADDR_INPUT_SELECT:     sel_word = input_select_q;
				`ADDR_STEERING:         sel_word = steering_q;
				`ADDR_SHUTDOWN_CONTROL: sel_word = shutdown_control_q;
				`ADDR_SHUTDOWN_SOURCES: sel_word = shutdown_sources_q;
				`ADDR_RISE_DEADBAND:    sel_word = {2'h0, rise_deadband_q};
				`ADDR_FALL_DEADBAND:    sel_word = {2'h0, fall_deadband_q};
				`ADDR_MODULE_DISABLE:   sel_word = {7'h00, module_disable_q};
				`ADDR_IRQ_STATUS:       sel_word = {6'h00, irq_status_q};
				`ADDR_IRQ_MASK:         sel_word = {6'h00, irq_mask_q};
				`ADDR_STATE:            sel_word = {4'h0, in_q, was_full_q, dead_q, dir_rev_q};
				default:                sel_word = `RESET_BYTE;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// generator reset and clock enable

	// disable bit gates the tick and holds the core in reset
	assign gen_rst   = RESET | module_disable_q;                         // [R6]
	assign tick      = !module_disable_q &&
	                   (clock_select_q[`CLK_SEL_BIT] ? ALT_CLK_EN : 1'b1); // [R6]
	assign mode      = control_main_q[`MODE_MSB:`MODE_LSB_BIT];
	assign full_mode = is_full(mode);
	assign enabled   = control_main_q[`CTRL_EN_BIT];
	assign mod_raw   = MOD_SOURCES[input_select_q[`ISM_MSB:`ISM_LSB]] ^ polarity_input_q[`POL_IN_BIT];
	// only the low mode bit may turn the bridge round on the fly
	assign dir_change = tick && enabled && full_mode && was_full_q &&
	                    (mode[`MODE_LSB_BIT] != dir_rev_q);              // [R5]
	assign db_len    = mode[`MODE_LSB_BIT] ? rise_deadband_q : fall_deadband_q; // [R7]

	////////////////////////////////////////////////////////////////
	// register port

	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			control_main_q     <= `RESET_BYTE;
			polarity_input_q   <= `RESET_BYTE;
			clock_select_q     <= `RESET_BYTE;
			input_select_q     <= `RESET_BYTE;
			steering_q         <= `RESET_BYTE;
			shutdown_control_q <= `RESET_BYTE;
			shutdown_sources_q <= `RESET_BYTE;
			rise_deadband_q    <= `RESET_COUNT;
			fall_deadband_q    <= `RESET_COUNT;
			module_disable_q   <= 1'b0;
			irq_mask_q         <= 2'h0;
			RDATA              <= `RESET_BYTE;
		end else begin
			RDATA <= RD ? sel_word(ADDR) : `RESET_BYTE;
			if (WR) begin
				case (ADDR)
					`ADDR_CONTROL_MAIN:     control_main_q     <= {WDATA[7:6], 3'h0, WDATA[2:0]}; // [R5]
					`ADDR_POLARITY_INPUT:   polarity_input_q   <= {2'h0, WDATA[5], 1'b0, WDATA[3:0]};
					`ADDR_CLOCK_SELECT:     clock_select_q     <= {7'h00, WDATA[0]};
					`ADDR_INPUT_SELECT:     input_select_q     <= {5'h00, WDATA[2:0]};
					`ADDR_STEERING:         steering_q         <= WDATA;
					`ADDR_SHUTDOWN_CONTROL: shutdown_control_q <= {WDATA[7:2], 2'h0};
					`ADDR_SHUTDOWN_SOURCES: shutdown_sources_q <= {2'h0, WDATA[5:0]};
					`ADDR_RISE_DEADBAND:    rise_deadband_q    <= WDATA[5:0];
					`ADDR_FALL_DEADBAND:    fall_deadband_q    <= WDATA[5:0];
					`ADDR_MODULE_DISABLE:   module_disable_q   <= WDATA[0];
					`ADDR_IRQ_MASK:         irq_mask_q         <= WDATA[1:0];
					default:                ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt status, set wins over write-one-to-clear

	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			irq_status_q <= 2'h0;
			IRQ          <= 1'b0;
		end else begin
			irq_status_q <= (irq_status_q &
			                 ~((WR && ADDR == `ADDR_IRQ_STATUS) ? WDATA[1:0] : 2'h0)) |
			                {db_done, dir_change};
			IRQ          <= |(irq_status_q & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////
	// direction and dead-band

	deadband_counter u_deadband (
		.clk    (SYS_CLK),
		.rst    (gen_rst),
		.tick   (tick),
		.start  (dir_change),
		.length (db_len),
		.busy_q (db_busy),
		.done_q (db_done)
	);

	always @(posedge SYS_CLK or posedge gen_rst) begin
		if (gen_rst) begin
			dir_rev_q  <= 1'b0;
			dead_q     <= 1'b0;
			in_q       <= 1'b0;
			was_full_q <= 1'b0;
		end else if (tick) begin
			in_q       <= mod_raw;
			was_full_q <= enabled && full_mode;
			if (enabled && full_mode && !was_full_q) begin
				// first entry: no opposing leg was on, no gap needed
				dir_rev_q <= mode[`MODE_LSB_BIT];
				dead_q    <= 1'b0;
			end else if (dir_change) begin
				dir_rev_q <= mode[`MODE_LSB_BIT];
				dead_q    <= 1'b1;                                        // [R3]
			end else if (!db_busy) begin
				dead_q    <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// output drive; steering bits never reach the full-bridge path

	always @(posedge SYS_CLK or posedge gen_rst) begin
		if (gen_rst) begin
			BRIDGE_OUT_A <= 1'b0;
			BRIDGE_OUT_B <= 1'b0;
			BRIDGE_OUT_C <= 1'b0;
			BRIDGE_OUT_D <= 1'b0;
		end else if (!enabled || !was_full_q) begin
			BRIDGE_OUT_A <= polarity_input_q[`POL_A_BIT];
			BRIDGE_OUT_B <= polarity_input_q[`POL_B_BIT];
			BRIDGE_OUT_C <= polarity_input_q[`POL_C_BIT];
			BRIDGE_OUT_D <= polarity_input_q[`POL_D_BIT];
		end else if (!dir_rev_q) begin
			// forward; D held off during the dead-band
			BRIDGE_OUT_A <= 1'b1 ^ polarity_input_q[`POL_A_BIT];                          // [R1] [R4]
			BRIDGE_OUT_B <= polarity_input_q[`POL_B_BIT];                                 // [R1]
			BRIDGE_OUT_C <= polarity_input_q[`POL_C_BIT];                                 // [R1]
			BRIDGE_OUT_D <= (in_q & !dead_q & !db_busy) ^ polarity_input_q[`POL_D_BIT];   // [R1] [R3]
		end else begin
			BRIDGE_OUT_A <= polarity_input_q[`POL_A_BIT];                                 // [R2] [R4]
			BRIDGE_OUT_B <= (in_q & !dead_q & !db_busy) ^ polarity_input_q[`POL_B_BIT];   // [R2] [R3]
			BRIDGE_OUT_C <= 1'b1 ^ polarity_input_q[`POL_C_BIT];                          // [R2]
			BRIDGE_OUT_D <= polarity_input_q[`POL_D_BIT];                                 // [R2]
		end
	end

endmodule

// *** verification/wave_bridge_props.sv ***
`include "wave_bridge_regs.vh"
module wave_bridge_props (
	// clock, reset and register strobe
	input wire logic       SYS_CLK,
	input wire logic       RESET,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	// bridge legs
	input wire logic       BRIDGE_OUT_A,
	input wire logic       BRIDGE_OUT_B,
	input wire logic       BRIDGE_OUT_C,
	input wire logic       BRIDGE_OUT_D
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (RESET);
	a_fwd_legs_fixed: assert property (BRIDGE_OUT_A |-> !BRIDGE_OUT_B && !BRIDGE_OUT_C)
		else $error("forward legs wrong");
	a_rev_legs_fixed: assert property (BRIDGE_OUT_C |-> !BRIDGE_OUT_A && !BRIDGE_OUT_D)
		else $error("reverse legs wrong");
	a_rev_dead_gap: assert property ($rose(BRIDGE_OUT_C) && $past(BRIDGE_OUT_A) |-> !BRIDGE_OUT_B)
		else $error("no gap toward reverse");
	a_fwd_dead_gap: assert property ($rose(BRIDGE_OUT_A) && $past(BRIDGE_OUT_C) |-> !BRIDGE_OUT_D)
		else $error("no gap toward forward");
	a_steer_ignored: assert property (WR && ADDR == `ADDR_STEERING && (BRIDGE_OUT_A || BRIDGE_OUT_C)
		|-> ##1 $stable({BRIDGE_OUT_A, BRIDGE_OUT_C})[*3]) else $error("steering moved a leg");
	a_flip_live: assert property (WR && ADDR == `ADDR_CONTROL_MAIN && WDATA == 8'h83 && BRIDGE_OUT_A
		|-> ##[1:5] BRIDGE_OUT_C) else $error("live flip not taken");
	a_disable_idle: assert property (WR && ADDR == `ADDR_MODULE_DISABLE && WDATA[0]
		|-> ##[1:4] !(BRIDGE_OUT_A || BRIDGE_OUT_B || BRIDGE_OUT_C || BRIDGE_OUT_D))
		else $error("disabled legs still driven");
endmodule
bind wave_bridge wave_bridge_props wave_bridge_props_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .BRIDGE_OUT_A(BRIDGE_OUT_A), .BRIDGE_OUT_B(BRIDGE_OUT_B),
	.BRIDGE_OUT_C(BRIDGE_OUT_C), .BRIDGE_OUT_D(BRIDGE_OUT_D));

// *** verification/bridge_switch_model.sv ***
module bridge_switch_model (
	// clock and watched legs
	input wire logic clk,
	input wire logic a,
	input wire logic b,
	input wire logic c,
	input wire logic d,
	// shoot-through count
	output int       faults
);
	timeunit 1ns;
	timeprecision 1ps;
	initial faults = 0;
	// one half-bridge with both switches on shorts the supply
	always @(posedge clk) begin
		if ((a && b) || (c && d))
			faults <= faults + 1;
	end
endmodule

// *** verification/tb.sv ***
`include "wave_bridge_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       SYS_CLK, RESET, WR, RD, ALT_CLK_EN, oc, rd_d, IRQ;
	logic       BRIDGE_OUT_A, BRIDGE_OUT_B, BRIDGE_OUT_C, BRIDGE_OUT_D;
	logic [3:0] ADDR;
	logic [7:0] WDATA, RDATA, MOD_SOURCES, m, e;
	logic [2:0] sel;
	logic [7:0] q_rd[$], q_out[$];
	int         n_errors, n_tests, faults, dir;
	wave_bridge wave_bridge_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .MOD_SOURCES(MOD_SOURCES), .ALT_CLK_EN(ALT_CLK_EN), .BRIDGE_OUT_A(BRIDGE_OUT_A),
		.BRIDGE_OUT_B(BRIDGE_OUT_B), .BRIDGE_OUT_C(BRIDGE_OUT_C), .BRIDGE_OUT_D(BRIDGE_OUT_D), .IRQ(IRQ));
	bridge_switch_model bridge_switch_model_i (.clk(SYS_CLK), .a(BRIDGE_OUT_A), .b(BRIDGE_OUT_B),
		.c(BRIDGE_OUT_C), .d(BRIDGE_OUT_D), .faults(faults));
	initial begin
		SYS_CLK = 1'b0;
		forever #20 SYS_CLK = ~SYS_CLK;
	end
	////////////////////////////////////////////////////////////////
	task cmp_rd(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: read %h expected %h", $time, got, exp);
		end
	endtask
	task cmp_out(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: legs %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] x);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD   <= 1'b1;
		q_rd.push_back(x);
		@(posedge SYS_CLK);
		RD <= 1'b0;
	endtask
	// bit 7 of a note means the interrupt level is not judged
	task chk(input logic [7:0] x);
		@(posedge SYS_CLK);
		q_out.push_back(x);
		oc <= 1'b1;
		@(posedge SYS_CLK);
		oc <= 1'b0;
	endtask
	task print_verdict;
		$display("comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge SYS_CLK) begin
		rd_d <= RD;
		if (rd_d)
			cmp_rd(RDATA, q_rd.pop_front());
		if (oc) begin
			e = q_out.pop_front();
			cmp_out({3'h0, IRQ & ~e[7], BRIDGE_OUT_A, BRIDGE_OUT_B,
				BRIDGE_OUT_C, BRIDGE_OUT_D}, e & 8'h1F);
		end
	end
	initial begin
		repeat (3000) @(posedge SYS_CLK);
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict;
	end
	initial begin
		{RESET, WR, RD, oc, ALT_CLK_EN} = 5'b10000;
		ADDR = 4'h0;
		WDATA = 8'h00;
		MOD_SOURCES = 8'h00;
		n_errors = 0;
		n_tests = 0;
		void'($urandom(32'hB19C2E3A));
		repeat (4) @(posedge SYS_CLK);
		RESET <= 1'b0;
		sel = $urandom % 8;
		m = $urandom;
		MOD_SOURCES <= m;
		wr(`ADDR_INPUT_SELECT, {5'h00, sel});
		wr(`ADDR_RISE_DEADBAND, 8'h05);
		wr(`ADDR_FALL_DEADBAND, 8'h03);
		wr(`ADDR_CONTROL_MAIN, 8'h82);
		wr(`ADDR_STEERING, 8'hFF);
		repeat (4) @(posedge SYS_CLK);
		chk({4'h0, 3'b100, m[sel]});
		rd(`ADDR_RISE_DEADBAND, 8'h05);
		rd(4'hD, 8'h00);
		$display("test forward done");
		wr(`ADDR_IRQ_MASK, 8'h01);
		MOD_SOURCES <= 8'hFF;
		// reverse first with the longer gap, then back to forward
		for (dir = 1; dir >= 0; dir--) begin
			wr(`ADDR_CONTROL_MAIN, 8'h82 | dir[7:0]);
			repeat (2) @(posedge SYS_CLK);
			chk(dir ? 8'h82 : 8'h88);
			repeat (10) @(posedge SYS_CLK);
			chk(dir ? 8'h16 : 8'h19);
			wr(`ADDR_IRQ_STATUS, 8'h03);
			repeat (2) @(posedge SYS_CLK);
			chk(dir ? 8'h06 : 8'h09);
			// live steering change while a leg is held must leave the legs alone
			wr(`ADDR_STEERING, 8'($urandom));
		end
		$display("test direction flips done");
		// generator clock taken from the enable pin, held off at first
		wr(`ADDR_CLOCK_SELECT, 8'h01);
		wr(`ADDR_CONTROL_MAIN, 8'hC3);
		repeat (4) @(posedge SYS_CLK);
		chk(8'h89);
		ALT_CLK_EN <= 1'b1;
		repeat (10) @(posedge SYS_CLK);
		chk(8'h86);
		wr(`ADDR_IRQ_STATUS, 8'h03);
		$display("test generator clock select done");
		wr(`ADDR_MODULE_DISABLE, 8'h01);
		repeat (3) @(posedge SYS_CLK);
		chk(8'h00);
		rd(`ADDR_RISE_DEADBAND, 8'h05);
		$display("test module disable done");
		repeat (2) @(posedge SYS_CLK);
		if (faults != 0) begin
			n_errors++;
			$display("mismatch at %0t: shoot-through seen", $time);
		end
		print_verdict;
	end
endmodule
